// ---- rtl/rco_clk_ctrl.sv ----
// Reference clock output and oscillator control, top level.
// Assumes a 10 MHz clk_sys_i, a register port that never waits, and
// oscillator clocks presented as levels synchronous to clk_sys_i.
module rco_clk_ctrl #(
  parameter int unsigned SECONDARY_OSCILLATOR_START_CYC = rco_pkg::SECONDARY_OSCILLATOR_START_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Register port.
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Clock sources as sampled levels.
  input  wire logic        primary_osc_lvl_i,
  input  wire logic        sysclk_lvl_i,
  // Device state and configuration.
  input  wire logic [2:0]  osc_mode_i,
  input  wire logic [2:0]  fast_rc_postscale_i,
  input  wire logic        sleep_i,
  input  wire logic        deep_sleep_i,
  input  wire logic [15:0] config_word_one_i,
  input  wire logic [15:0] config_word_three_i,
  input  wire logic        secondary_oscillator_module_req_i,
  input  wire logic        usb_req_i,
  // Outputs towards pins and other blocks.
  output logic             refclk_out_pin_o,
  output logic             refclk_out_oe_n_o,
  output logic             sysclk_half_out_pin_o,
  output logic             sysclk_half_oe_n_o,
  output logic             primary_osc_power_o,
  output logic             secondary_osc_en_o,
  output logic             secondary_osc_digital_o,
  output logic             secondary_osc_ready_o,
  output logic             retention_reg_enable_o,
  output logic             usb_clk_en_o
);

  // Software-visible registers, then half-rate clock state.
  logic [15:0] refctl_reg;    // Reference clock control.
  logic [15:0] resetctl_reg;  // Reset control, retention bit only.
  logic [15:0] oscctl_reg;    // Secondary force and primary keep bits.
  logic [15:0] rdata_reg;     // Read data, valid the cycle after a read.
  logic        half_reg;      // Half-rate system clock.
  logic        sys_q_reg;     // Last sample of the system clock.

  // Field views of the control registers and configuration words.
  wire         ref_oe    = refctl_reg[rco_pkg::REF_OE_BIT];
  wire         ref_slp   = refctl_reg[rco_pkg::REF_SLP_BIT];
  wire         ref_sel   = refctl_reg[rco_pkg::REF_SEL_BIT];
  wire   [3:0] ref_div   = refctl_reg[rco_pkg::REF_DIV_LSB +:
                                      rco_pkg::REF_DIV_W];
  wire         ret_fw    = resetctl_reg[rco_pkg::RET_EN_BIT];
  wire         secondary_oscillator_frc  = oscctl_reg[rco_pkg::OSC_FORCE_BIT];
  wire         posc_keep = oscctl_reg[rco_pkg::OSC_KEEP_BIT];
  wire         ret_cfg   = config_word_one_i[rco_pkg::CW1_RETCFG_BIT];
  wire         secondary_oscillator_pin  = config_word_three_i[rco_pkg::CW3_SOSCPIN_BIT];

  // Address decode, one select per register.
  wire sel_ref = (reg_addr_i == rco_pkg::REFCTL_ADDR);
  wire sel_rst = (reg_addr_i == rco_pkg::RESETCTL_ADDR);
  wire sel_osc = (reg_addr_i == rco_pkg::OSCCTL_ADDR);
  wire sel_st  = (reg_addr_i == rco_pkg::STATUS_ADDR);

  // Oscillator mode classes.
  wire mode_primary;  // External clock or crystal primary modes.
  wire mode_usb_ok;   // Modes that may clock the USB module.
  wire mode_half_out; // Modes that leave the half-rate pin free.
  wire rc_usb_freq;   // Fast RC postscale gives 4 MHz or 8 MHz.

  // Derived control.
  wire posc_on;       // Primary oscillator powered.
  wire ref_allowed;   // Reference output allowed in the present state.
  wire ref_clk;       // Divided and gated reference clock.
  wire secondary_oscillator_on;
  wire secondary_oscillator_rdy;
  wire ret_on;
  wire [15:0] status;
  logic [15:0] rdata_next;

  // Mode decode. Primary modes, with or without the PLL, use the
  // oscillator on the primary pins.
  assign mode_primary =
      (osc_mode_i == rco_pkg::OSC_CRYSTAL)     |
      (osc_mode_i == rco_pkg::OSC_HS_CRYSTAL)  |
      (osc_mode_i == rco_pkg::OSC_EXT_CLOCK)   |
      (osc_mode_i == rco_pkg::OSC_CRYSTAL_PLL) |
      (osc_mode_i == rco_pkg::OSC_HS_PLL)      |
      (osc_mode_i == rco_pkg::OSC_EXT_PLL);

  // The fast RC only feeds USB at the two postscale settings that give
  // the PLL a valid input; software is expected to pick one.
  assign rc_usb_freq =
      (fast_rc_postscale_i == rco_pkg::FAST_RC_POSTSCALE_8MHZ) |
      (fast_rc_postscale_i == rco_pkg::FAST_RC_POSTSCALE_4MHZ);

  // Only PLL modes clock USB; there is no separate USB clock input.
  assign mode_usb_ok =
      ((osc_mode_i == rco_pkg::OSC_FAST_RC_PLL) & rc_usb_freq) |
      (osc_mode_i == rco_pkg::OSC_CRYSTAL_PLL) |
      (osc_mode_i == rco_pkg::OSC_HS_PLL)      |
      (osc_mode_i == rco_pkg::OSC_EXT_PLL);

  // A crystal occupies the second primary pin, so the half-rate clock
  // can only appear in the other modes.
  assign mode_half_out =
      (osc_mode_i == rco_pkg::OSC_FAST_RC)     |
      (osc_mode_i == rco_pkg::OSC_FAST_RC_PLL) |
      (osc_mode_i == rco_pkg::OSC_EXT_CLOCK)   |
      (osc_mode_i == rco_pkg::OSC_EXT_PLL);

  assign usb_clk_en_o = usb_req_i & mode_usb_ok;

  // The primary oscillator stops in Sleep unless the keep bit holds it.
  assign posc_on = ~sleep_i | posc_keep;
  assign primary_osc_power_o = posc_on;

  // In Sleep the system clock is gone, so only the primary source with
  // the sleep-run bit set, in a primary mode, still has a clock to show.
  assign ref_allowed = ~sleep_i |
      (ref_slp & ref_sel & mode_primary & posc_on);

  // Retention regulator: power-saving state and both enables.
  assign ret_on = (sleep_i | deep_sleep_i)
                & ~ret_cfg & ret_fw;
  assign retention_reg_enable_o = ret_on;

  // Reference divider; it latches new settings only between periods.
  rco_ref_div u_ref_div (
    .clk_sys_i     (clk_sys_i),
    .resetn_i      (resetn_i),
    .primary_lvl_i (primary_osc_lvl_i),
    .system_lvl_i  (sysclk_lvl_i),
    .sel_i         (ref_sel),
    .div_i         (ref_div),
    .en_i          (ref_oe & ref_allowed),
    .clk_o         (ref_clk)
  );

  // The pin stays with the reference function while it is enabled, so
  // a held-low level is seen during Sleep, not a floating pin.
  assign refclk_out_pin_o  = ref_clk;
  assign refclk_out_oe_n_o = ~ref_oe;

  // Secondary oscillator with automatic and forced start.
  rco_secondary_oscillator_ctrl #(
    .START_CYC (SECONDARY_OSCILLATOR_START_CYC)
  ) u_secondary_oscillator (
    .clk_sys_i      (clk_sys_i),
    .resetn_i       (resetn_i),
    .pin_cfg_i      (secondary_oscillator_pin),
    .force_on_i     (secondary_oscillator_frc),
    .module_req_i   (secondary_oscillator_module_req_i),
    .osc_en_o       (secondary_oscillator_on),
    .pins_digital_o (secondary_osc_digital_o),
    .ready_o        (secondary_oscillator_rdy)
  );
  assign secondary_osc_en_o    = secondary_oscillator_on;
  assign secondary_osc_ready_o = secondary_oscillator_rdy;

  // Status word showing live block state.
  assign status = {10'h000,
                   posc_on,
                   ref_oe & ref_allowed,
                   mode_usb_ok,
                   ret_on,
                   secondary_oscillator_on,
                   secondary_oscillator_rdy};

  // Read mux; unmapped addresses read as zero.
  assign rdata_next = !reg_rd_i ? 16'h0000
                    : sel_ref   ? refctl_reg
                    : sel_rst   ? resetctl_reg
                    : sel_osc   ? oscctl_reg
                    : sel_st    ? status
                    : 16'h0000;
  assign reg_rdata_o = rdata_reg;

  // Register writes; unimplemented bits stay zero through the masks.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      refctl_reg   <= rco_pkg::REFCTL_RST;
      resetctl_reg <= rco_pkg::RESETCTL_RST;
      oscctl_reg   <= rco_pkg::OSCCTL_RST;
    end
    else if (reg_wr_i)
    begin
      if (sel_ref)
        refctl_reg <= reg_wdata_i & rco_pkg::REFCTL_WMASK;
      else if (sel_rst)
        resetctl_reg <= reg_wdata_i & rco_pkg::RESETCTL_WMASK;
      else if (sel_osc)
        oscctl_reg <= reg_wdata_i & rco_pkg::OSCCTL_WMASK;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  // Half-rate system clock: toggles on each sampled system clock rise.
  // It stops low outside the modes that free the pin.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sys_q_reg <= 1'b0;
      half_reg  <= 1'b0;
    end
    else
    begin
      sys_q_reg <= sysclk_lvl_i;
      if (!mode_half_out)
        half_reg <= 1'b0;
      else if (sysclk_lvl_i & ~sys_q_reg)
        half_reg <= ~half_reg;
    end
  end
  assign sysclk_half_out_pin_o = half_reg;
  assign sysclk_half_oe_n_o    = ~mode_half_out;

endmodule

// ---- rtl/rco_pkg.sv ----
// Shared constants for the reference clock and oscillator control block.
// Assumes a 10 MHz system clock and a 16-bit register port with word
// addresses.
package rco_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // Register word addresses.
  localparam logic [3:0] REFCTL_ADDR   = 4'h0;
  localparam logic [3:0] RESETCTL_ADDR = 4'h1;
  localparam logic [3:0] OSCCTL_ADDR   = 4'h2;
  localparam logic [3:0] STATUS_ADDR   = 4'h3;

  // Reference clock control fields.
  localparam int unsigned REF_OE_BIT  = 15;
  localparam int unsigned REF_SLP_BIT = 13;
  localparam int unsigned REF_SEL_BIT = 12;
  localparam int unsigned REF_DIV_LSB = 8;
  localparam int unsigned REF_DIV_W   = 4;

  // Reset control, oscillator control and configuration word fields.
  localparam int unsigned RET_EN_BIT     = 12;
  localparam int unsigned OSC_FORCE_BIT  = 0;
  localparam int unsigned OSC_KEEP_BIT   = 1;
  localparam int unsigned CW3_SOSCPIN_BIT = 8;
  localparam int unsigned CW1_RETCFG_BIT = 10;

  // Status register fields.
  localparam int unsigned ST_SECONDARY_OSCILLATOR_RDY_BIT = 0;
  localparam int unsigned ST_SECONDARY_OSCILLATOR_ON_BIT  = 1;
  localparam int unsigned ST_RET_BIT      = 2;
  localparam int unsigned ST_USB_OK_BIT   = 3;
  localparam int unsigned ST_REF_ON_BIT   = 4;
  localparam int unsigned ST_POSC_ON_BIT  = 5;

  // Reset values and writable masks.
  localparam logic [15:0] REFCTL_RST    = 16'h0000;
  localparam logic [15:0] REFCTL_WMASK  = 16'hbf00;
  localparam logic [15:0] RESETCTL_RST  = 16'h0000;
  localparam logic [15:0] RESETCTL_WMASK = 16'h1000;
  localparam logic [15:0] OSCCTL_RST    = 16'h0000;
  localparam logic [15:0] OSCCTL_WMASK  = 16'h0003;

  // Fast RC postscaler settings that give a USB-capable frequency.
  localparam logic [2:0] FAST_RC_POSTSCALE_8MHZ = 3'h0;
  localparam logic [2:0] FAST_RC_POSTSCALE_4MHZ = 3'h1;

  // Timing: clock rate and secondary oscillator start-up time.
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned SECONDARY_OSCILLATOR_START_S   = 1;
  localparam int unsigned SECONDARY_OSCILLATOR_START_CYC = SECONDARY_OSCILLATOR_START_S * CLK_HZ;

  // Device oscillator modes as seen by this block.
  typedef enum logic [2:0] {
    OSC_FAST_RC     = 3'b000,
    OSC_FAST_RC_PLL = 3'b001,
    OSC_CRYSTAL     = 3'b010,
    OSC_HS_CRYSTAL  = 3'b011,
    OSC_EXT_CLOCK   = 3'b100,
    OSC_CRYSTAL_PLL = 3'b101,
    OSC_HS_PLL      = 3'b110,
    OSC_EXT_PLL     = 3'b111
  } rco_osc_mode_t;

endpackage

// ---- rtl/rco_secondary_oscillator_ctrl.sv ----
// Secondary oscillator enable and start-up timer.
// Assumes the module request and force bit are synchronous to clk_sys_i.
module rco_secondary_oscillator_ctrl #(
  parameter int unsigned START_CYC = rco_pkg::SECONDARY_OSCILLATOR_START_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic pin_cfg_i,
  input  wire logic force_on_i,
  input  wire logic module_req_i,
  output logic      osc_en_o,
  output logic      pins_digital_o,
  output logic      ready_o
);

  localparam int unsigned CW = $clog2(START_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(START_CYC - 1);

  // Oscillator runs on demand or when forced, but only with its pins
  // configured for oscillator use.
  logic          run;
  logic [CW-1:0] cnt_reg;     // Start-up cycles seen so far.
  logic          ready_reg;   // Clock usable after the full start-up.
  logic          done;

  assign run            = pin_cfg_i & (force_on_i | module_req_i);
  assign pins_digital_o = ~pin_cfg_i;
  assign osc_en_o       = run;
  assign done           = (cnt_reg == LAST);
  assign ready_o        = ready_reg;

  // Start-up timer; any stop restarts it, since the crystal must settle
  // again from rest.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_reg   <= '0;
      ready_reg <= 1'b0;
    end
    else if (!run)
    begin
      cnt_reg   <= '0;
      ready_reg <= 1'b0;
    end
    else if (!done)
    begin
      cnt_reg   <= cnt_reg + CW'(1);
    end
    else
    begin
      ready_reg <= 1'b1;
    end
  end

endmodule

// ---- rtl/rco_ref_div.sv ----
// Glitch-free reference clock divider with source selection.
// Assumes both source clocks arrive as levels sampled by clk_sys_i, so
// each source must run below half the system clock rate.
module rco_ref_div (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic       primary_lvl_i,
  input  wire logic       system_lvl_i,
  input  wire logic       sel_i,
  input  wire logic [3:0] div_i,
  input  wire logic       en_i,
  output logic            clk_o
);

  logic        sel_reg;     // Active source, taken at a period boundary.
  logic [3:0]  div_reg;     // Active divide setting.
  logic        en_reg;      // Active output gate.
  logic        prim_q_reg;  // Last sample of each source.
  logic        sys_q_reg;
  logic        div_out_reg; // Divided clock before gating.
  logic        pin_reg;     // Gated clock towards the pin.
  logic [14:0] cnt_reg;     // Source edges within a half period.
  logic        rise;
  logic        src;
  logic [14:0] half_last;
  logic        boundary;
  logic        div_out_next;
  logic        en_now;      // Output gate that applies at this edge.

  // Each source has its own edge detector so that a source change never
  // fabricates an edge.
  assign rise = sel_reg ? (primary_lvl_i & ~prim_q_reg)
                        : (system_lvl_i & ~sys_q_reg);
  assign src  = sel_reg ? primary_lvl_i : system_lvl_i;
  // Setting n divides by two to the n; zero passes the source through.
  assign half_last = (div_reg == 4'h0) ? 15'h0000
                   : 15'((15'h0001 << (div_reg - 4'h1)) - 15'h0001);
  // Settings change only while the output is low at a half-period start.
  assign boundary  = ~div_out_reg & (cnt_reg == 15'h0000);
  assign div_out_next = (div_reg == 4'h0) ? src
                      : (rise && cnt_reg == half_last) ? ~div_out_reg
                      : div_out_reg;
  assign clk_o = pin_reg;
  // A new gate takes effect at the boundary edge itself. Using the old
  // gate there would let one short high cycle through on a disable.
  assign en_now = boundary ? en_i : en_reg;

  // Source sampling, counter and divided clock.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prim_q_reg  <= 1'b0;
      sys_q_reg   <= 1'b0;
      cnt_reg     <= 15'h0000;
      div_out_reg <= 1'b0;
    end
    else
    begin
      prim_q_reg  <= primary_lvl_i;
      sys_q_reg   <= system_lvl_i;
      div_out_reg <= div_out_next;
      if (div_reg == 4'h0 || (rise && cnt_reg == half_last))
        cnt_reg <= 15'h0000;
      else if (rise)
        cnt_reg <= cnt_reg + 15'h0001;
    end
  end

  // Settings and gate change together at a boundary, so no runt pulse.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sel_reg <= 1'b0;
      div_reg <= 4'h0;
      en_reg  <= 1'b0;
      pin_reg <= 1'b0;
    end
    else
    begin
      if (boundary)
      begin
        sel_reg <= sel_i;
        div_reg <= div_i;
        en_reg  <= en_i;
      end
      pin_reg <= en_now & div_out_next;
    end
  end

endmodule

// ---- bench/rco_clk_ctrl_checker.sv ----
// Port-level assertions for the reference clock and oscillator control top.
// Assumes it is bound to rco_clk_ctrl and sees only that module's ports.
module rco_clk_ctrl_checker #(
  parameter int unsigned SECONDARY_OSCILLATOR_START_CYC = 8
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_rdata_o,
  input  wire logic [2:0]  osc_mode_i,
  input  wire logic [2:0]  fast_rc_postscale_i,
  input  wire logic        sleep_i,
  input  wire logic        deep_sleep_i,
  input  wire logic [15:0] config_word_one_i,
  input  wire logic [15:0] config_word_three_i,
  input  wire logic        secondary_oscillator_module_req_i,
  input  wire logic        usb_req_i,
  input  wire logic        refclk_out_oe_n_o,
  input  wire logic        sysclk_half_oe_n_o,
  input  wire logic        primary_osc_power_o,
  input  wire logic        secondary_osc_en_o,
  input  wire logic        secondary_osc_digital_o,
  input  wire logic        secondary_osc_ready_o,
  input  wire logic        retention_reg_enable_o,
  input  wire logic        usb_clk_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  logic [31:0] en_cnt_reg;  // Enabled cycles of the secondary oscillator.

  // Saturating count, so a one-second start-up cannot overflow it.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i)
      en_cnt_reg <= '0;
    else if (!secondary_osc_en_o)
      en_cnt_reg <= '0;
    else if (en_cnt_reg < SECONDARY_OSCILLATOR_START_CYC + 4)
      en_cnt_reg <= en_cnt_reg + 1;

  oe_follow_a: assert property (
    reg_wr_i && reg_addr_i == rco_pkg::REFCTL_ADDR |=>
    refclk_out_oe_n_o == !$past(reg_wdata_i[15])) else $error("oe mismatch");
  ctl_readback_a: assert property (
    (reg_wr_i && reg_addr_i == 4'h0 ##2 reg_rd_i && reg_addr_i == 4'h0) |=>
    reg_rdata_o == ($past(reg_wdata_i, 3) & 16'hbf00))
    else $error("control readback wrong");
  secondary_oscillator_auto_a: assert property (
    config_word_three_i[8] && secondary_oscillator_module_req_i |-> secondary_osc_en_o)
    else $error("secondary osc not started by request");
  secondary_oscillator_pins_a: assert property (
    !config_word_three_i[8] |-> !secondary_osc_en_o && secondary_osc_digital_o)
    else $error("secondary osc pins not digital");
  secondary_oscillator_wait_a: assert property (
    secondary_osc_ready_o |-> en_cnt_reg >= SECONDARY_OSCILLATOR_START_CYC)
    else $error("secondary osc ready too early");
  secondary_oscillator_ready_a: assert property (
    en_cnt_reg >= SECONDARY_OSCILLATOR_START_CYC + 3 |-> secondary_osc_ready_o)
    else $error("secondary osc ready too late");
  posc_run_a: assert property (!sleep_i |-> primary_osc_power_o)
    else $error("primary osc off while running");
  ret_gate_a: assert property (retention_reg_enable_o |->
    (sleep_i || deep_sleep_i) && !config_word_one_i[10])
    else $error("retention regulator on wrongly");
  usb_mode_a: assert property (usb_clk_en_o |-> usb_req_i &&
    (osc_mode_i inside {3'h5, 3'h6, 3'h7} ||
     osc_mode_i == 3'h1 && fast_rc_postscale_i[2:1] == 2'h0))
    else $error("usb clock in bad mode");
  half_oe_a: assert property (sysclk_half_oe_n_o ==
    !(osc_mode_i inside {3'h0, 3'h1, 3'h4, 3'h7}))
    else $error("half rate pin enable wrong");

  cover property (secondary_osc_ready_o);
  cover property (retention_reg_enable_o);
  cover property (usb_clk_en_o);
endmodule

// ---- bench/rco_ext_device.sv ----
// External device clocked from the reference clock pin.
// Assumes the pin is sampled on clk_sys_i; it reports half periods in cycles.
module rco_ext_device (
  input  wire logic clk_sys_i,
  input  wire logic refclk_pin_i,
  output int        half_len_o,
  output int        edges_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_lvl = 1'b0;  // Pin level seen at the previous edge.
  int   run_len  = 0;     // Cycles since the last change of level.

  // Measures each level's length; the last one stands until the next change.
  always @(posedge clk_sys_i)
  begin
    run_len <= run_len + 1;
    if (refclk_pin_i !== last_lvl)
    begin
      half_len_o <= run_len + 1;
      edges_o    <= edges_o + 1;
      run_len    <= 0;
    end
    last_lvl <= refclk_pin_i;
  end
endmodule

// ---- bench/test_reference_clock_and_osc_control.sv ----
// Self-checking bench for the reference clock and oscillator control top.
// Assumes the package and design files are compiled before it.
module test_reference_clock_and_osc_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int START = 8;     // Shortened start-up of the secondary osc.
  localparam int LIMIT = 20000; // Cycle ceiling for the whole run.
  localparam logic [15:0] MASK [3] = '{rco_pkg::REFCTL_WMASK,
    rco_pkg::RESETCTL_WMASK, rco_pkg::OSCCTL_WMASK};
  logic clk_sys_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0]  reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, reg_rdata_o, d;
  logic primary_osc_lvl_i = 0, sysclk_lvl_i = 0, sleep_i = 0;
  logic deep_sleep_i = 0, secondary_oscillator_module_req_i = 0, usb_req_i = 0;
  logic [2:0]  osc_mode_i = 0, fast_rc_postscale_i = 0;
  logic [15:0] config_word_one_i = 0, config_word_three_i = 0;
  logic refclk_out_pin_o, refclk_out_oe_n_o, sysclk_half_out_pin_o;
  logic sysclk_half_oe_n_o, primary_osc_power_o, secondary_osc_en_o;
  logic secondary_osc_digital_o, secondary_osc_ready_o;
  logic retention_reg_enable_o, usb_clk_en_o;
  logic [15:0] lfsr_reg = 16'h004d;  // Seed of the random stream.
  int n_errors = 0, tests_run = 0, cyc = 0, a, h, exp, e0, half_len, edges;
  int sys_half = 2, pri_half = 3;    // Source half periods in cycles.
  int mdl[3];                        // Model of the writable registers.

  rco_clk_ctrl #(.SECONDARY_OSCILLATOR_START_CYC(START)) i_dut (.*);
  rco_ext_device i_ext (.clk_sys_i, .refclk_pin_i(refclk_out_pin_o),
    .half_len_o(half_len), .edges_o(edges));

  always #50 clk_sys_i = ~clk_sys_i;

  // Source clocks as levels, plus the hang guard.
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc % sys_half == 0) sysclk_lvl_i <= !sysclk_lvl_i;
    if (cyc % pri_half == 0) primary_osc_lvl_i <= !primary_osc_lvl_i;
    if (cyc == LIMIT)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // One write cycle; the extra edge keeps strobes apart.
  task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
    reg_addr_i <= ad;
    reg_wdata_i <= dt;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] ad, output logic [15:0] dt);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    dt = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 3; i++)
    begin
      rd(4'(i), d);
      chk(d, 0);
      mdl[i] = 0;
    end
    wr(4'h7, 16'hffff);  // An unmapped place ignores writes.
    rd(4'h7, d);
    chk(d, 0);
    repeat (8)
    begin
      lfsr_reg = lfsr_next(lfsr_reg);
      a = lfsr_reg[3:0] % 3;
      wr(4'(a), lfsr_reg);
      mdl[a] = lfsr_reg & MASK[a];
      rd(4'(a), d);
      chk(d, mdl[a]);
    end
    // Every source and the low dividers; the system rate switches too.
    for (int n = 0; n < 4; n++)
      for (int s = 0; s < 2; s++)
      begin
        sys_half = 2 + n % 2;
        h = s ? pri_half : sys_half;
        exp = (n == 0) ? h : (1 << (n - 1)) * 2 * h;
        wr(rco_pkg::REFCTL_ADDR, 16'(32'h8000 | (s << 12) | (n << 8)));
        repeat (6 * exp + 80) @(posedge clk_sys_i);
        chk(half_len, exp);
        chk(refclk_out_oe_n_o, 0);
      end
    wr(rco_pkg::REFCTL_ADDR, 16'h0000);
    // The old setting runs on until its next boundary, up to two halves.
    repeat (60) @(posedge clk_sys_i);
    chk(refclk_out_pin_o, 0);
    chk(refclk_out_oe_n_o, 1);
    // Sleep with the primary kept alive and sleep-run set on it.
    osc_mode_i <= rco_pkg::OSC_EXT_CLOCK;
    wr(rco_pkg::OSCCTL_ADDR, 16'h0002);
    wr(rco_pkg::REFCTL_ADDR, 16'hb100);
    sleep_i <= 1'b1;
    e0 = edges;
    repeat (60) @(posedge clk_sys_i);
    chk(edges > e0 + 4, 1);
    chk(half_len, 2 * pri_half);
    chk(primary_osc_power_o, 1);
    wr(rco_pkg::REFCTL_ADDR, 16'h9100);
    repeat (60) @(posedge clk_sys_i);
    chk(refclk_out_pin_o, 0);
    wr(rco_pkg::OSCCTL_ADDR, 16'h0000);
    @(negedge clk_sys_i);
    chk(primary_osc_power_o, 0);
    @(posedge clk_sys_i);
    sleep_i <= 1'b0;
    // Secondary oscillator: pins, request, start-up and force bit.
    secondary_oscillator_module_req_i <= 1'b1;
    @(negedge clk_sys_i);
    chk({secondary_osc_en_o, secondary_osc_digital_o}, 2'b01);
    @(posedge clk_sys_i);
    config_word_three_i <= 16'h0100;
    @(negedge clk_sys_i);
    chk({secondary_osc_en_o, secondary_osc_digital_o}, 2'b10);
    repeat (START - 1) @(posedge clk_sys_i);
    chk(secondary_osc_ready_o, 0);
    repeat (4) @(posedge clk_sys_i);
    chk(secondary_osc_ready_o, 1);
    secondary_oscillator_module_req_i <= 1'b0;
    wr(rco_pkg::OSCCTL_ADDR, 16'h0001);
    chk(secondary_osc_en_o, 1);
    wr(rco_pkg::OSCCTL_ADDR, 16'h0000);
    chk(secondary_osc_en_o, 0);
    // Retention regulator over every combination of its conditions.
    for (int i = 0; i < 16; i++)
    begin
      wr(rco_pkg::RESETCTL_ADDR, i[0] ? 16'h1000 : 16'h0000);
      sleep_i <= i[3];
      deep_sleep_i <= i[2];
      config_word_one_i <= i[1] ? 16'h0400 : 16'h0000;
      @(negedge clk_sys_i);
      chk(retention_reg_enable_o, (i[3] | i[2]) & !i[1] & i[0]);
      @(posedge clk_sys_i);
    end
    sleep_i <= 1'b0;
    deep_sleep_i <= 1'b0;
    // Every oscillator mode against postscale and request.
    for (int m = 0; m < 8; m++)
      for (int p = 0; p < 4; p++)
      begin
        osc_mode_i <= 3'(m);
        fast_rc_postscale_i <= 3'(p);
        usb_req_i <= (p != 3);
        @(negedge clk_sys_i);
        exp = (m >= 5 || (m == 1 && p < 2)) && p != 3;
        chk(usb_clk_en_o, exp);
        chk(sysclk_half_oe_n_o, !(m < 2 || m == 4 || m == 7));
        @(posedge clk_sys_i);
      end
    // Half-rate pin: held low in a crystal mode, half duty otherwise.
    osc_mode_i <= rco_pkg::OSC_CRYSTAL;
    repeat (2) @(posedge clk_sys_i);
    chk(sysclk_half_out_pin_o, 0);
    osc_mode_i <= rco_pkg::OSC_EXT_CLOCK;
    e0 = 0;
    repeat (8) @(posedge clk_sys_i);
    repeat (24) @(negedge clk_sys_i) e0 += sysclk_half_out_pin_o;
    chk(e0, 12);
    @(posedge clk_sys_i);
    // Status ignores writes; primary powered and reference allowed.
    wr(rco_pkg::STATUS_ADDR, 16'hffff);
    rd(rco_pkg::STATUS_ADDR, d);
    chk(d, 16'h0030);
    tally_and_finish();
  end
endmodule

bind rco_clk_ctrl rco_clk_ctrl_checker #(.SECONDARY_OSCILLATOR_START_CYC(SECONDARY_OSCILLATOR_START_CYC))
  i_chk (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .osc_mode_i, .fast_rc_postscale_i, .sleep_i,
  .deep_sleep_i, .config_word_one_i, .config_word_three_i,
  .secondary_oscillator_module_req_i, .usb_req_i, .refclk_out_oe_n_o, .sysclk_half_oe_n_o,
  .primary_osc_power_o, .secondary_osc_en_o, .secondary_osc_digital_o,
  .secondary_osc_ready_o, .retention_reg_enable_o, .usb_clk_en_o);
